/* hw/fetch_tag.sv */
/*
  Icache tag qualification: address space tagging of fills, match on
  fetch, and kernel superpage mapping. Assumes requests on ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iucs_map.svh"

module fetch_tag (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [5:0]  asn_i,
  input  wire logic        map_en_i,
  input  wire logic        kernel_i,
  input  wire logic        fetch_req_i,
  input  wire logic [42:13] fetch_va_i,
  input  wire logic [5:0]  line_asn_i,
  input  wire logic        line_asm_i,
  input  wire logic        fill_req_i,
  input  wire logic [1:0]  fill_va_hi_i,
  output logic             fetch_done_o,
  output logic             fetch_hit_o,
  output logic             sp_bypass_o,
  output logic [33:13]     sp_pa_o,
  output logic             fill_wr_o,
  output logic [5:0]       fill_asn_o,
  output logic             fill_asm_o
);

  logic        match;
  logic        sp_fetch;
  logic        sp_fill;
  logic [33:13] va_mid;

  assign va_mid   = fetch_va_i[33:13];
  assign match    = line_asm_i | (line_asn_i == asn_i);
  assign sp_fetch = map_en_i & kernel_i &
                    (fetch_va_i[42:41] == `SP_REGION);
  assign sp_fill  = map_en_i & kernel_i & (fill_va_hi_i == `SP_REGION);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_done_o <= 1'b0;
      fetch_hit_o  <= 1'b0;
      sp_bypass_o  <= 1'b0;
      sp_pa_o      <= '0;
    end else begin
      fetch_done_o <= fetch_req_i;
      fetch_hit_o  <= fetch_req_i & match;
      sp_bypass_o  <= fetch_req_i & sp_fetch;
      if (fetch_req_i && sp_fetch) begin
        sp_pa_o <= va_mid;
      end
    end
  end

  // A mismatch never writes the cache; only fills do
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill_wr_o  <= 1'b0;
      fill_asn_o <= '0;
      fill_asm_o <= 1'b0;
    end else begin
      fill_wr_o <= fill_req_i;
      if (fill_req_i) begin
        fill_asn_o <= asn_i;
        fill_asm_o <= sp_fill;
      end
    end
  end

  a_asn_miss: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fetch_req_i && !match |=> fetch_done_o && !fetch_hit_o)
    else $error("mismatching fetch taken as hit");

  a_fill_asn: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fill_req_i |=> fill_wr_o && fill_asn_o == $past(asn_i))
    else $error("fill lost its address space");

  a_sp_map: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fetch_req_i && sp_fetch |=> sp_bypass_o && sp_pa_o == $past(va_mid))
    else $error("superpage address not passed");

  a_sp_user: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fetch_req_i && (!kernel_i || !map_en_i) |=> !sp_bypass_o)
    else $error("superpage outside kernel or disabled");

endmodule
`default_nettype wire

/* hw/issue_control_status_register.sv */
/*
  Issue unit control and status register with the issue policy it
  steers: float and reserved opcode traps, dual issue, return stack,
  drain mode, branch prediction, and two performance counters.
  Assumes move-to/from strobes, decoded instructions and pipeline events
  on ref_clk_i; external count pins are asynchronous.
*/
// Functional notes
// - Fills store current address space; fetches compare against it.
// - Address space mismatch invalidates fetch, cache untouched.
// - Both counters stop when both enables clear, else count.
// - Float enable allows float issue; clear traps every float op.
// - Superpage: VA[42:41]==2 bypasses translation, PA[33:13]=VA[33:13].
// - Superpage only in kernel, sets match bit, off when disabled.
// - Privileged opcode enable lets five opcodes issue in kernel.
// - Dual issue enable permits two issues per cycle, else one.
// - Return stack enable lets calls push return address.
// - Drain mode: interlocked ops drain pipe and write buffer.
// - Register moves, returns, cond branches, R31 writes skip drain.
// - Counter 1 interrupts after 2^12 events, or 2^8 if set.
// - Counter 0 interrupts after 2^16 events, or 2^12 if set.
// - Prediction: off not taken; else sign or history table.
// - Reset clears register except address space and range bits.
// - Counters start at zero on power-up, never cleared later.
// - Counter overflow interrupt comes six cycles after the event.
// - Counter 1 select picks one of eight events in order.
`timescale 1ns/1ps
`default_nettype none
`include "iucs_map.svh"

module issue_control_status_register (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            por_n_i,
  input  wire logic            iucs_wr_i,
  input  wire logic            iucs_rd_i,
  input  wire logic [63:0]     iucs_wdata_i,
  output logic [63:0]          iucs_rdata_o,
  output logic                 iucs_rvalid_o,
  input  wire logic            pal_mode_i,
  input  wire logic            kernel_i,
  input  wire iucs_pkg::insn_t insn_i,
  output logic                 issue_hold_o,
  output logic                 drain_start_o,
  output logic                 fp_issue_ok_o,
  output logic                 float_disabled_trap_o,
  output logic                 rsv_issue_ok_o,
  output logic                 reserved_opcode_trap_o,
  output logic                 dual_issue_enable_o,
  output logic                 rs_push_o,
  input  wire logic            pipe_empty_i,
  input  wire logic            wbuf_empty_i,
  input  wire logic            branch_disp_neg_i,
  input  wire logic            bht_taken_i,
  output logic                 predict_taken_o,
  input  wire iucs_pkg::evt_t  evt_i,
  input  wire logic [1:0]      perf_ext_i,
  output logic [1:0]           perf_irq_o,
  input  wire logic            fetch_req_i,
  input  wire logic [42:13]    fetch_va_i,
  input  wire logic [5:0]      line_asn_i,
  input  wire logic            line_asm_i,
  input  wire logic            fill_req_i,
  input  wire logic [1:0]      fill_va_hi_i,
  output logic                 fetch_done_o,
  output logic                 fetch_hit_o,
  output logic                 sp_bypass_o,
  output logic [33:13]         sp_pa_o,
  output logic                 fill_wr_o,
  output logic [5:0]           fill_asn_o,
  output logic                 fill_asm_o
);
  import iucs_pkg::*;

  logic [5:0]   address_space_number;
  logic         counter1_range_select;
  logic         counter0_range_select;
  logic [1:0]   res_bits;
  logic [1:0]   perf_count_enables;
  logic         float_enable;
  logic         map_enable;
  logic         privileged_opcode_enable;
  logic         dual_issue_enable;
  logic         history_predict_enable;
  logic         return_stack_enable;
  logic         branch_predict_enable;
  logic         pipe_enable;
  logic [2:0]   counter1_event_select;
  logic [3:0]   counter0_event_select;
  logic         count_en;
  logic [1:0]   ext_meta;
  logic [1:0]   ext_sync;
  logic         half_acc;
  logic [1:0]   half_sum;
  logic         next_half;
  logic         ev0;
  logic         ev1;
  logic         drain_exempt;
  drain_state_t state;
  drain_state_t next_state;

  // Kept across hardware reset; only power-up sets a value
  always_ff @(posedge ref_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      address_space_number  <= '0;
      counter1_range_select <= 1'b0;
      counter0_range_select <= 1'b0;
    end else if (iucs_wr_i && rst_n_i) begin
      address_space_number  <= iucs_wdata_i[`W_ASN];
      counter1_range_select <= iucs_wdata_i[`W_PC1];
      counter0_range_select <= iucs_wdata_i[`W_PC0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_bits                 <= '0;
      perf_count_enables       <= '0;
      float_enable             <= `CTRL_RESET;
      map_enable               <= `CTRL_RESET;
      privileged_opcode_enable <= `CTRL_RESET;
      dual_issue_enable        <= `CTRL_RESET;
      history_predict_enable   <= `CTRL_RESET;
      return_stack_enable      <= `CTRL_RESET;
      branch_predict_enable    <= `CTRL_RESET;
      pipe_enable              <= `CTRL_RESET;
      counter1_event_select    <= '0;
      counter0_event_select    <= '0;
    end else if (iucs_wr_i) begin
      res_bits <= {iucs_wdata_i[`W_RESH], iucs_wdata_i[`W_RESL]};
      perf_count_enables       <= iucs_wdata_i[`W_PCE];
      float_enable             <= iucs_wdata_i[`W_FPE];
      map_enable               <= iucs_wdata_i[`W_MAP];
      privileged_opcode_enable <= iucs_wdata_i[`W_HWE];
      dual_issue_enable        <= iucs_wdata_i[`W_DI];
      history_predict_enable   <= iucs_wdata_i[`W_BHE];
      return_stack_enable      <= iucs_wdata_i[`W_JSE];
      branch_predict_enable    <= iucs_wdata_i[`W_BPE];
      pipe_enable              <= iucs_wdata_i[`W_PIPE];
      counter1_event_select    <= iucs_wdata_i[`W_MUX1];
      counter0_event_select    <= iucs_wdata_i[`W_MUX0];
    end
  end

  // Read image uses its own bit positions; all other bits read zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iucs_rdata_o  <= '0;
      iucs_rvalid_o <= 1'b0;
    end else begin
      iucs_rvalid_o <= iucs_rd_i;
      if (iucs_rd_i) begin
        iucs_rdata_o            <= '0;
        iucs_rdata_o[`R_PCE]    <= perf_count_enables;
        iucs_rdata_o[`R_RESH]   <= res_bits[1];
        iucs_rdata_o[`R_ASN]    <= address_space_number;
        iucs_rdata_o[`R_RESL]   <= res_bits[0];
        iucs_rdata_o[`R_FPE]    <= float_enable;
        iucs_rdata_o[`R_MAP]    <= map_enable;
        iucs_rdata_o[`R_HWE]    <= privileged_opcode_enable;
        iucs_rdata_o[`R_DI]     <= dual_issue_enable;
        iucs_rdata_o[`R_BHE]    <= history_predict_enable;
        iucs_rdata_o[`R_JSE]    <= return_stack_enable;
        iucs_rdata_o[`R_BPE]    <= branch_predict_enable;
        iucs_rdata_o[`R_PIPE]   <= pipe_enable;
        iucs_rdata_o[`R_MUX1]   <= counter1_event_select;
        iucs_rdata_o[`R_MUX0]   <= counter0_event_select;
        iucs_rdata_o[`R_PC1]    <= counter1_range_select;
        iucs_rdata_o[`R_PC0]    <= counter0_range_select;
      end
    end
  end

  // Issue policy
  assign fp_issue_ok_o = insn_i.valid & insn_i.fp & float_enable;
  assign float_disabled_trap_o = insn_i.valid & insn_i.fp &
                                 ~float_enable;
  assign rsv_issue_ok_o = insn_i.valid & insn_i.rsv &
                          (pal_mode_i |
                           (privileged_opcode_enable & kernel_i));
  assign reserved_opcode_trap_o = insn_i.valid & insn_i.rsv &
                                  ~rsv_issue_ok_o;
  assign dual_issue_enable_o = dual_issue_enable;
  assign rs_push_o = insn_i.valid & insn_i.call &
                     return_stack_enable;
  assign predict_taken_o = branch_predict_enable &
                           (history_predict_enable ? bht_taken_i
                                                   : branch_disp_neg_i);

  assign drain_exempt = insn_i.mtpr | insn_i.rei | insn_i.cond_br |
                        insn_i.dest_r31;
  assign drain_start_o = (state == ST_RUN) & insn_i.valid &
                         insn_i.interlocked & ~pipe_enable &
                         ~drain_exempt;
  assign issue_hold_o = (state == ST_DRAIN);

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (drain_start_o) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (pipe_empty_i && wbuf_empty_i) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // External count pins
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
          ext_meta[gi] <= 1'b0;
          ext_sync[gi] <= 1'b0;
        end else begin
          ext_meta[gi] <= perf_ext_i[gi];
          ext_sync[gi] <= ext_meta[gi];
        end
      end
    end
  endgenerate

  assign count_en = |perf_count_enables;

  // Halved counts carry through one accumulator bit
  always_comb begin
    half_sum = 2'h0;
    ev0      = 1'b0;
    case (counter0_event_select[3:1])
      3'h0: half_sum = {1'b0, half_acc} +
                       (evt_i.issue_two ? 2'h2 : {1'b0, evt_i.issue_one});
      3'h1: ev0 = evt_i.dry;
      3'h2: ev0 = evt_i.load;
      3'h3: ev0 = evt_i.frozen;
      3'h4: ev0 = evt_i.branch;
      3'h5: ev0 = counter0_event_select[0] ? evt_i.pal_cycle : 1'b1;
      3'h6: half_sum = {1'b0, half_acc} + {1'b0, evt_i.no_issue};
      3'h7: ev0 = ext_sync[0];
      default: ev0 = 1'b0;
    endcase
    next_half = half_acc;
    if (counter0_event_select[3:1] == 3'h0 ||
        counter0_event_select[3:1] == 3'h6) begin
      ev0       = half_sum[1];
      next_half = half_sum[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      half_acc <= 1'b0;
    end else if (count_en) begin
      half_acc <= next_half;
    end
  end

  always_comb begin
    case (counter1_event_select)
      3'h0: ev1 = evt_i.dcache_miss;
      3'h1: ev1 = evt_i.icache_miss;
      3'h2: ev1 = evt_i.issue_two;
      3'h3: ev1 = evt_i.mispredict;
      3'h4: ev1 = evt_i.fp_op;
      3'h5: ev1 = evt_i.int_op;
      3'h6: ev1 = evt_i.store;
      3'h7: ev1 = ext_sync[1];
      default: ev1 = 1'b0;
    endcase
  end

  perf_counter #(.LONG(`C0_LONG), .SHORT(`C0_SHORT)) u_cnt0 (
    .ref_clk_i  (ref_clk_i),
    .por_n_i    (por_n_i),
    .count_en_i (count_en),
    .event_i    (ev0),
    .short_i    (counter0_range_select),
    .irq_o      (perf_irq_o[0])
  );

  perf_counter #(.LONG(`C1_LONG), .SHORT(`C1_SHORT)) u_cnt1 (
    .ref_clk_i  (ref_clk_i),
    .por_n_i    (por_n_i),
    .count_en_i (count_en),
    .event_i    (ev1),
    .short_i    (counter1_range_select),
    .irq_o      (perf_irq_o[1])
  );

  fetch_tag u_fetch (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .asn_i        (address_space_number),
    .map_en_i     (map_enable),
    .kernel_i     (kernel_i),
    .fetch_req_i  (fetch_req_i),
    .fetch_va_i   (fetch_va_i),
    .line_asn_i   (line_asn_i),
    .line_asm_i   (line_asm_i),
    .fill_req_i   (fill_req_i),
    .fill_va_hi_i (fill_va_hi_i),
    .fetch_done_o (fetch_done_o),
    .fetch_hit_o  (fetch_hit_o),
    .sp_bypass_o  (sp_bypass_o),
    .sp_pa_o      (sp_pa_o),
    .fill_wr_o    (fill_wr_o),
    .fill_asn_o   (fill_asn_o),
    .fill_asm_o   (fill_asm_o)
  );

  sequence s_fpe_off;
    iucs_wr_i && !iucs_wdata_i[`W_FPE];
  endsequence

  a_fpe_trap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fpe_off ##1 (insn_i.valid && insn_i.fp && !iucs_wr_i) |->
    float_disabled_trap_o && !fp_issue_ok_o)
    else $error("float op issued while disabled");

  a_rsv_trap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    insn_i.valid && insn_i.rsv && !pal_mode_i &&
    !privileged_opcode_enable |-> reserved_opcode_trap_o)
    else $error("reserved opcode not trapped");

  a_single_issue: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    iucs_wr_i && !iucs_wdata_i[`W_DI] |=> !dual_issue_enable_o)
    else $error("dual issue left on");

  a_drain_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    drain_start_o |=> issue_hold_o)
    else $error("no hold after drain start");

  a_drain_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    issue_hold_o && !(pipe_empty_i && wbuf_empty_i) |=> issue_hold_o)
    else $error("hold released before empty");

  a_drain_skip: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    drain_exempt || pipe_enable |-> !drain_start_o)
    else $error("exempt instruction drained");

  a_bp_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    iucs_wr_i && !iucs_wdata_i[`W_BPE] ##1 !iucs_wr_i |-> !predict_taken_o)
    else $error("predicted taken while off");

  a_reset_keep: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    !rst_n_i |=> address_space_number == $past(address_space_number))
    else $error("address space lost in reset");

endmodule
`default_nettype wire

/* hw/iucs_map.svh */
/*
  Bit layout, reset values and timing counts of the issue unit control
  and status register. Assumes inclusion by bare name, once or more.
*/
`ifndef IUCS_MAP_SVH
`define IUCS_MAP_SVH

// Write image
`define W_ASN   52:47
`define W_RESH  46
`define W_PCE   45:44
`define W_FPE   42
`define W_MAP   41
`define W_HWE   40
`define W_DI    39
`define W_BHE   38
`define W_JSE   37
`define W_BPE   36
`define W_PIPE  35
`define W_MUX1  34:32
`define W_MUX0  11:8
`define W_RESL  4
`define W_PC1   1
`define W_PC0   0

// Read image
`define R_PCE   45:44
`define R_RESH  35
`define R_ASN   33:28
`define R_RESL  24
`define R_FPE   23
`define R_MAP   22
`define R_HWE   21
`define R_DI    20
`define R_BHE   19
`define R_JSE   18
`define R_BPE   17
`define R_PIPE  16
`define R_MUX1  15:13
`define R_MUX0  12:9
`define R_PC1   2
`define R_PC0   1

`define CTRL_RESET  1'b0
`define C0_LONG     16
`define C0_SHORT    12
`define C1_LONG     12
`define C1_SHORT    8
`define IRQ_DELAY   6
`define SP_REGION   2'h2

`endif

/* hw/iucs_pkg.sv */
/*
  Types shared by the issue unit control block and its helpers.
  Assumes iucs_map.svh is on the include path.
*/
package iucs_pkg;

  typedef struct packed {
    logic valid;
    logic fp;
    logic rsv;
    logic call;
    logic interlocked;
    logic mtpr;
    logic rei;
    logic cond_br;
    logic dest_r31;
  } insn_t;

  typedef struct packed {
    logic dcache_miss;
    logic icache_miss;
    logic issue_one;
    logic issue_two;
    logic no_issue;
    logic dry;
    logic frozen;
    logic load;
    logic branch;
    logic mispredict;
    logic fp_op;
    logic int_op;
    logic store;
    logic pal_cycle;
  } evt_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_DRAIN = 2'b10
  } drain_state_t;

endpackage

/* hw/perf_counter.sv */
/*
  One free-running performance counter with two overflow ranges and a
  fixed-latency interrupt request. Assumes events on ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iucs_map.svh"

module perf_counter #(
  parameter int LONG  = 16,
  parameter int SHORT = 12
) (
  input  wire logic ref_clk_i,
  input  wire logic por_n_i,
  input  wire logic count_en_i,
  input  wire logic event_i,
  input  wire logic short_i,
  output logic      irq_o
);

  logic [LONG-1:0]       count;
  logic [`IRQ_DELAY-1:0] dly;
  logic                  at_short;
  logic                  at_long;
  logic                  wrap;

  assign at_short = &count[SHORT-1:0];
  assign at_long  = &count;
  assign wrap     = count_en_i & event_i & (short_i ? at_short : at_long);

  // Cleared only by power-up, then accumulates forever
  always_ff @(posedge ref_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      count <= '0;
    end else if (count_en_i && event_i) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      dly <= '0;
    end else begin
      dly <= {dly[`IRQ_DELAY-2:0], wrap};
    end
  end

  assign irq_o = dly[`IRQ_DELAY-1];

  sequence s_wrap;
    wrap;
  endsequence

  a_irq_delay: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    s_wrap |-> ##6 irq_o) else $error("overflow not reported 6 later");

  a_cnt_stop: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    !count_en_i |=> $stable(count)) else $error("counter moved");

  a_irq_range: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    irq_o |-> ($past(short_i, 6) ? $past(at_short, 6) : $past(at_long, 6)))
    else $error("irq at wrong range");

endmodule
`default_nettype wire

/* verif/tb.sv */
/*
  Self-checking bench for the issue unit control and status register.
  Assumes the hw/ sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iucs_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, por_n_i = 0, iucs_wr_i = 0;
  logic iucs_rd_i = 0, pal_mode_i = 0, kernel_i = 0, line_asm_i = 0;
  logic pipe_empty_i = 0, wbuf_empty_i = 0, fill_req_i = 0;
  logic branch_disp_neg_i = 0, bht_taken_i = 0, fetch_req_i = 0;
  logic [1:0]  fill_va_hi_i = 0, perf_ext_i = 0, perf_irq_o;
  logic [63:0] iucs_wdata_i = 0, iucs_rdata_o, w;
  logic [42:13] fetch_va_i = 0;
  logic [5:0]  line_asn_i = 0, fill_asn_o;
  logic [33:13] sp_pa_o;
  logic [29:0] ft;
  insn_t       insn_i = '0;
  evt_t        evt_i = '0;
  logic iucs_rvalid_o, issue_hold_o, drain_start_o, fp_issue_ok_o;
  logic float_disabled_trap_o, rsv_issue_ok_o, reserved_opcode_trap_o;
  logic dual_issue_enable_o, rs_push_o, predict_taken_o, fetch_done_o;
  logic fetch_hit_o, sp_bypass_o, fill_wr_o, fill_asm_o;
  int miscompares = 0, comparisons = 0, cyc = 0;
  logic [63:0] rdq[$];
  logic [29:0] ftq[$];
  int irqq[$];

  issue_control_status_register dut (.ref_clk_i, .rst_n_i, .por_n_i,
    .iucs_wr_i, .iucs_rd_i, .iucs_wdata_i, .iucs_rdata_o, .iucs_rvalid_o,
    .pal_mode_i, .kernel_i, .insn_i, .issue_hold_o, .drain_start_o,
    .fp_issue_ok_o, .float_disabled_trap_o, .rsv_issue_ok_o,
    .reserved_opcode_trap_o, .dual_issue_enable_o, .rs_push_o,
    .pipe_empty_i, .wbuf_empty_i, .branch_disp_neg_i, .bht_taken_i,
    .predict_taken_o, .evt_i, .perf_ext_i, .perf_irq_o, .fetch_req_i,
    .fetch_va_i, .line_asn_i, .line_asm_i, .fill_req_i, .fill_va_hi_i,
    .fetch_done_o, .fetch_hit_o, .sp_bypass_o, .sp_pa_o, .fill_wr_o,
    .fill_asn_o, .fill_asm_o);

  always #10 ref_clk_i = ~ref_clk_i;

  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Read image as the register presents a given write image
  function automatic logic [63:0] img(logic [63:0] d);
    img = '0;
    img[45:44] = d[45:44];
    img[35] = d[46];
    img[33:28] = d[52:47];
    img[24] = d[4];
    img[23:13] = d[42:32];
    img[12:9] = d[11:8];
    img[2:1] = d[1:0];
  endfunction

  task automatic wr(logic [63:0] d);
    @(posedge ref_clk_i);
    iucs_wr_i <= 1'b1;
    iucs_wdata_i <= d;
    @(posedge ref_clk_i);
    iucs_wr_i <= 1'b0;
  endtask

  task automatic rd(logic [63:0] e);
    @(posedge ref_clk_i);
    iucs_rd_i <= 1'b1;
    rdq.push_back(e);
    @(posedge ref_clk_i);
    iucs_rd_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  task automatic fetch(logic k, logic [42:13] va, logic [5:0] la);
    logic b;
    b = w[41] & k & (va[42:41] == 2'h2);
    @(posedge ref_clk_i);
    kernel_i <= k;
    fetch_va_i <= va;
    line_asn_i <= la;
    fetch_req_i <= 1'b1;
    fill_req_i <= 1'b1;
    fill_va_hi_i <= va[42:41];
    ftq.push_back({la == w[52:47], b, va[33:13], w[52:47], b});
    @(posedge ref_clk_i);
    fetch_req_i <= 1'b0;
    fill_req_i <= 1'b0;
  endtask

  task automatic pulses(int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      evt_i.dcache_miss <= 1'b1;
      @(posedge ref_clk_i);
      evt_i.dcache_miss <= 1'b0;
    end
  endtask

  // Result watcher and hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      finish_test();
    end
    if (iucs_rvalid_o === 1'b1)
      check("rdata", iucs_rdata_o, rdq.pop_front());
    if (fetch_done_o === 1'b1) begin
      ft = ftq.pop_front();
      check("hit", fetch_hit_o, ft[29]);
      check("bypass", sp_bypass_o, ft[28]);
      if (ft[28])
        check("pa", sp_pa_o, ft[27:7]);
      check("fill", {fill_wr_o, fill_asn_o, fill_asm_o}, {1'b1, ft[6:0]});
    end
    if (perf_irq_o[1] === 1'b1)
      check("irq_cycle", cyc, irqq.pop_front());
    if (perf_irq_o[0] === 1'b1)
      check("irq0_cycle", cyc, irqq.pop_front());
  end

  initial begin
    int i;
    void'($urandom(32'hf2b0be05));
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    w = {$urandom, $urandom} & 64'h001f_f7ff_0000_0f13;
    // Odd counter 0 selects see no events here, so its count stays zero
    w[8] = 1'b1;
    wr(w);
    rd(img(w));
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(img(w) & 64'h0000_0003_f000_0006);
    $display("register test done");
    for (i = 0; i < 4; i++) begin
      wr({21'h0, i[0], 1'b0, i[1], i[1], i[1], i[0], i[0], 1'b1, 35'h0});
      @(posedge ref_clk_i);
      kernel_i <= 1'b1;
      insn_i <= '{valid: 1'b1, fp: 1'b1, rsv: 1'b1, call: 1'b1, default: 1'b0};
      branch_disp_neg_i <= 1'($urandom);
      bht_taken_i <= 1'($urandom);
      @(negedge ref_clk_i);
      check("fp_ok", {fp_issue_ok_o, float_disabled_trap_o}, {i[0], !i[0]});
      check("rsv", {rsv_issue_ok_o, reserved_opcode_trap_o}, {i[1], !i[1]});
      check("dual", dual_issue_enable_o, i[1]);
      check("push", rs_push_o, i[0]);
      check("predict", predict_taken_o,
            i[0] & (i[1] ? bht_taken_i : branch_disp_neg_i));
    end
    $display("issue test done");
    wr(64'h0);
    @(posedge ref_clk_i);
    insn_i <= '{valid: 1'b1, interlocked: 1'b1, mtpr: 1'b1, default: 1'b0};
    @(negedge ref_clk_i);
    check("exempt", drain_start_o, 1'b0);
    @(posedge ref_clk_i);
    insn_i.mtpr <= 1'b0;
    @(negedge ref_clk_i);
    check("drain", drain_start_o, 1'b1);
    @(posedge ref_clk_i);
    insn_i <= '0;
    @(negedge ref_clk_i);
    check("hold", issue_hold_o, 1'b1);
    @(posedge ref_clk_i);
    pipe_empty_i <= 1'b1;
    wbuf_empty_i <= 1'b1;
    @(negedge ref_clk_i);
    check("wait", issue_hold_o, 1'b1);
    @(negedge ref_clk_i);
    check("release", issue_hold_o, 1'b0);
    $display("drain test done");
    w = 64'h0000_0200_0000_0000;
    w[52:47] = 6'($urandom);
    wr(w);
    for (i = 0; i < 4; i++)
      fetch(i[0], {i[1], 1'b0, 28'($urandom)}, w[52:47] ^ {5'h0, i == 1});
    w[41] = 1'b0;
    wr(w);
    fetch(1'b1, {2'h2, 28'($urandom)}, w[52:47]);
    $display("fetch test done");
    wr(64'h0000_0000_0000_0002);
    pulses(100);
    wr(64'h0000_1000_0000_0002);
    pulses(256);
    @(negedge ref_clk_i);
    irqq.push_back(cyc + 6);
    // Counter 0: upper enable only, every cycle, short range
    wr(64'h0000_2000_0000_0a01);
    @(negedge ref_clk_i);
    irqq.push_back(cyc + 4096 + 6);
    repeat (4108) @(posedge ref_clk_i);
    check("pending", irqq.size() + ftq.size() + rdq.size(), 0);
    $display("counter test done");
    finish_test();
  end
endmodule
`default_nettype wire
